// >>> fcg_pkg.sv
// =====================================================================
// Shared constants for the flash command guard
package fcg_pkg;
    // Power-up delay, longest time, rounded down to whole cycles
    localparam int PU_DELAY_US = 300;
    localparam int CLK_MHZ = 40;
    localparam int PU_CYCLES = PU_DELAY_US * CLK_MHZ;
    localparam int PU_CNT_W = 16;
    // Clock pulse counting
    localparam int CNT_W = 12;
    localparam int BYTE_BITS = 8;
    localparam logic [CNT_W-1:0] CNT_OPCODE = 12'h008;
    localparam logic [CNT_W-1:0] CNT_CFG_BYTE = 12'h018;
    // Configuration register one layout and reset value
    localparam int LAT_POS = 6;
    localparam int QUAD_POS = 1;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Dummy cycles per latency code, four bits per code
    localparam logic [15:0] DUMMY_TBL = 16'h8888;
    localparam logic [3:0] MODE_CYC_QIO = 4'h2;
    // Command codes
    localparam logic [7:0] OP_REG_WRITE = 8'h01;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_WRITE_EN = 8'h06;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_SECT_ERASE = 8'hD8;
    localparam logic [7:0] OP_BULK_ERASE = 8'h60;
    localparam logic [7:0] OP_QUAD_PROG = 8'h32;
    localparam logic [7:0] OP_QUAD_OREAD = 8'h6B;
    localparam logic [7:0] OP_QUAD_IOREAD = 8'hEB;
    localparam logic [7:0] OP_DDR_QIOREAD = 8'hED;
    localparam logic [7:0] OP_SOFT_RESET = 8'hF0;
    // Guard state machine
    typedef enum logic [3:0] {
        ST_OFF = 4'b0001,
        ST_POR = 4'b0010,
        ST_STBY = 4'b0100,
        ST_FAULT = 4'b1000
    } fcg_state_e;
endpackage

// >>> fcg_link.sv
`timescale 1ns/1ps
// =====================================================================
// Serial clock side: counts pulses and captures opcode and last byte
module fcg_link #(
    parameter int CNT_W = 12
) (
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic io0_i,
    output logic [CNT_W-1:0] pulse_cnt_o,
    output logic [7:0] opcode_o,
    output logic [7:0] data_o
);
    logic fresh_q;

    // Marks the first edge of a frame; set while select is high
    always_ff @(posedge sck_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    // Pulse counter, saturating, restarted on a frame's first edge
    always_ff @(posedge sck_i) begin
        if (fresh_q) begin
            pulse_cnt_o <= {{(CNT_W-1){1'b0}}, 1'b1};
        end else if (!(&pulse_cnt_o)) begin
            pulse_cnt_o <= pulse_cnt_o + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Input shifter and opcode capture on the eighth bit
    always_ff @(posedge sck_i) begin
        if (fresh_q) begin
            data_o <= {7'h00, io0_i};
        end else begin
            data_o <= {data_o[6:0], io0_i};
        end
        if (!fresh_q && pulse_cnt_o == {{(CNT_W-3){1'b0}}, 3'h7}) begin
            opcode_o <= {data_o[6:0], io0_i};
        end
    end
endmodule

// >>> fcg_top.sv
`timescale 1ns/1ps
module fcg_top #(
    parameter int PU_CYCLES = fcg_pkg::PU_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic io0_i,
    input wire logic rst_pin_n_i,
    input wire logic vcc_min_ok_i,
    input wire logic vcc_cutoff_ok_i,
    output logic ready_o,
    output logic por_active_o,
    output logic cmd_accept_o,
    output logic cmd_discard_o,
    output logic [7:0] cmd_opcode_o,
    output logic write_enable_latch_o,
    output logic quad_mode_o,
    output logic hold_wp_ignore_o,
    output logic [1:0] latency_code_o,
    output logic [3:0] dummy_cycles_o,
    output logic [3:0] mode_cycles_o
);
    import fcg_pkg::*;

    // =================================================================
    // Link side and input synchronisers
    logic [fcg_pkg::CNT_W-1:0] pulse_cnt;
    logic [7:0] link_op;
    logic [7:0] link_data;
    logic [3:0] raw_in;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic cs_s, vmin_s, vcut_s, rst_pin_s;

    fcg_link #(.CNT_W(CNT_W)) u_link (
        .sck_i(sck_i),
        .cs_n_i(cs_n_i),
        .io0_i(io0_i),
        .pulse_cnt_o(pulse_cnt),
        .opcode_o(link_op),
        .data_o(link_data)
    );

    assign raw_in = {rst_pin_n_i, vcc_cutoff_ok_i, vcc_min_ok_i, cs_n_i};

    // Two-stage synchroniser per pin
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge core_clk_i) begin
                if (reset_i) begin
                    sync1_q[gi] <= (gi == 0) ? 1'b1 : 1'b0;
                    sync2_q[gi] <= (gi == 0) ? 1'b1 : 1'b0;
                end else if (clk_en_i) begin
                    sync1_q[gi] <= raw_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    assign cs_s = sync2_q[0];
    assign vmin_s = sync2_q[1];
    assign vcut_s = sync2_q[2];
    assign rst_pin_s = sync2_q[3];

    // =================================================================
    // Frame end detection; link words are static while select is high
    logic frame_open_q;
    logic frame_end;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            frame_open_q <= 1'b0;
        end else if (clk_en_i) begin
            frame_open_q <= !cs_s;
        end
    end

    assign frame_end = cs_s && frame_open_q;

    // =================================================================
    // Command classification
    logic [7:0] cfg_q;
    logic wel_q;
    logic cut_ok;
    logic has_op, byte_ok, guarded, quad_only, ddr_quad, is_read, need_wel;
    logic cmd_ok;
    logic soft_reset;

    assign cut_ok = vcut_s;
    assign has_op = pulse_cnt >= CNT_OPCODE;
    assign byte_ok = pulse_cnt[2:0] == 3'h0;
    assign guarded = link_op inside {OP_PAGE_PROG, OP_QUAD_PROG, OP_SECT_ERASE,
                                     OP_BULK_ERASE, OP_REG_WRITE};
    assign need_wel = guarded;
    assign quad_only = link_op inside {OP_QUAD_PROG, OP_QUAD_OREAD, OP_QUAD_IOREAD};
    assign ddr_quad = link_op == OP_DDR_QIOREAD;
    assign is_read = link_op inside {OP_FAST_READ, OP_QUAD_OREAD, OP_QUAD_IOREAD,
                                     OP_DDR_QIOREAD};
    assign soft_reset = frame_end && has_op && link_op == OP_SOFT_RESET;

    // Accept only permitted commands with a whole opcode; whole bytes are required of guarded commands only
    always_comb begin
        cmd_ok = has_op && cut_ok;
        if (guarded && !byte_ok) begin
            cmd_ok = 1'b0;
        end
        if (quad_only && !cfg_q[QUAD_POS]) begin
            cmd_ok = 1'b0;
        end
        if (ddr_quad && !cfg_q[QUAD_POS]) begin
            cmd_ok = 1'b0;
        end
        if (need_wel && !wel_q) begin
            cmd_ok = 1'b0;
        end
    end

    // =================================================================
    // Power-up and power-on reset sequencing
    fcg_state_e state_q;
    logic [PU_CNT_W-1:0] pu_cnt_q;
    logic pu_done;

    assign pu_done = pu_cnt_q == PU_CNT_W'(PU_CYCLES - 1);

    // Guard state machine
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_q <= ST_OFF;
        end else if (clk_en_i) begin
            case (state_q)
                ST_OFF: begin
                    if (vmin_s && vcut_s) begin
                        state_q <= ST_POR;
                    end
                end
                ST_POR: begin
                    if (!vcut_s) begin
                        state_q <= ST_OFF;
                    end else if (!vmin_s) begin
                        state_q <= ST_FAULT;
                    end else if (pu_done) begin
                        state_q <= ST_STBY;
                    end
                end
                ST_STBY: begin
                    if (!vcut_s) begin
                        state_q <= ST_OFF;
                    end
                end
                ST_FAULT: begin
                    if (!vcut_s) begin
                        state_q <= ST_OFF;
                    end else if (vmin_s && (!rst_pin_s || soft_reset)) begin
                        state_q <= ST_POR;
                    end
                end
                default: begin
                    state_q <= ST_OFF;
                end
            endcase
        end
    end

    // Power-up delay counter, runs only in power-on reset
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pu_cnt_q <= '0;
        end else if (clk_en_i) begin
            if (state_q == ST_POR && !pu_done) begin
                pu_cnt_q <= pu_cnt_q + PU_CNT_W'(1);
            end else if (state_q != ST_POR) begin
                pu_cnt_q <= '0;
            end
        end
    end

    assign ready_o = state_q[2];
    assign por_active_o = state_q[1];

    // =================================================================
    // Command outcome and device state
    logic take;

    assign take = frame_end && state_q == ST_STBY && has_op;

    // Accept or discard pulses
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            cmd_accept_o <= 1'b0;
            cmd_discard_o <= 1'b0;
            cmd_opcode_o <= 8'h00;
        end else if (clk_en_i) begin
            cmd_accept_o <= take && cmd_ok;
            cmd_discard_o <= take && !cmd_ok;
            if (take && cmd_ok) begin
                cmd_opcode_o <= link_op;
            end
        end
    end

    // Write enable latch, cleared through power-on reset
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            wel_q <= 1'b0;
        end else if (clk_en_i) begin
            if (state_q != ST_STBY) begin
                wel_q <= 1'b0;
            end else if (take && cmd_ok && link_op == OP_WRITE_EN) begin
                wel_q <= 1'b1;
            end else if (take && cmd_ok && need_wel) begin
                wel_q <= 1'b0;
            end
        end
    end

    assign write_enable_latch_o = wel_q;

    // Configuration write only by an accepted register write
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            cfg_q <= CFG_RESET;
        end else if (clk_en_i) begin
            if (take && cmd_ok && link_op == OP_REG_WRITE && pulse_cnt == CNT_CFG_BYTE) begin
                cfg_q <= link_data;
            end
        end
    end

    assign quad_mode_o = cfg_q[QUAD_POS];
    assign hold_wp_ignore_o = cfg_q[QUAD_POS];
    assign latency_code_o = cfg_q[LAT_POS +: 2];

    // Read latency for the last accepted read
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            dummy_cycles_o <= 4'h0;
            mode_cycles_o <= 4'h0;
        end else if (clk_en_i) begin
            if (take && cmd_ok && is_read) begin
                dummy_cycles_o <= DUMMY_TBL[{cfg_q[LAT_POS +: 2], 2'b00} +: 4];
                mode_cycles_o <= (link_op == OP_QUAD_IOREAD || ddr_quad) ? MODE_CYC_QIO : 4'h0;
            end
        end
    end

    // =================================================================
    // Checks
    property p_count_guard;
        @(posedge core_clk_i iff clk_en_i) disable iff (reset_i)
        take && guarded && !byte_ok |=> cmd_discard_o && !cmd_accept_o;
    endproperty
    a_count_guard: assert property (p_count_guard) else $error("odd pulse count taken");

    property p_discard_keeps;
        @(posedge core_clk_i iff clk_en_i) disable iff (reset_i)
        take && !cmd_ok |=> cfg_q == $past(cfg_q) && wel_q == $past(wel_q);
    endproperty
    a_discard_keeps: assert property (p_discard_keeps) else $error("discard changed state");

    property p_no_accept_off;
        @(posedge core_clk_i iff clk_en_i) disable iff (reset_i)
        state_q != ST_STBY |=> !cmd_accept_o;
    endproperty
    a_no_accept_off: assert property (p_no_accept_off) else $error("accept outside standby");

    property p_pu_length;
        @(posedge core_clk_i iff clk_en_i) disable iff (reset_i)
        $rose(ready_o) |-> $past(pu_cnt_q) == PU_CNT_W'(PU_CYCLES - 1);
    endproperty
    a_pu_length: assert property (p_pu_length) else $error("power-up delay wrong");

    property p_stby_wel;
        @(posedge core_clk_i iff clk_en_i) disable iff (reset_i)
        $rose(ready_o) |-> !write_enable_latch_o;
    endproperty
    a_stby_wel: assert property (p_stby_wel) else $error("latch set at standby");

    property p_quad_need;
        @(posedge core_clk_i iff clk_en_i) disable iff (reset_i)
        take && quad_only && !quad_mode_o |=> cmd_discard_o;
    endproperty
    a_quad_need: assert property (p_quad_need) else $error("quad command without mode");

    property p_ddr_need;
        @(posedge core_clk_i iff clk_en_i) disable iff (reset_i)
        take && ddr_quad && !quad_mode_o |=> !cmd_accept_o;
    endproperty
    a_ddr_need: assert property (p_ddr_need) else $error("ddr quad without mode");

    property p_cutoff;
        @(posedge core_clk_i iff clk_en_i) disable iff (reset_i)
        !vcut_s |=> !cmd_accept_o ##1 !ready_o;
    endproperty
    a_cutoff: assert property (p_cutoff) else $error("command below cut-off");

    property p_restart;
        @(posedge core_clk_i iff clk_en_i) disable iff (reset_i)
        state_q == ST_FAULT && vcut_s && vmin_s && !rst_pin_s |=> por_active_o;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart from fault");

    property p_latency;
        @(posedge core_clk_i iff clk_en_i) disable iff (reset_i)
        take && cmd_ok && is_read |=>
            dummy_cycles_o == DUMMY_TBL[{$past(cfg_q[7:6]), 2'b00} +: 4];
    endproperty
    a_latency: assert property (p_latency) else $error("dummy count wrong");
endmodule

// >>> fcg_host_model.sv
`timescale 1ns/1ps
// ========================================
// Host serial controller, one frame per call
module fcg_host_model (
    output logic sck_o,
    output logic cs_n_o,
    output logic io0_o
);
    // Deselected at power-up, link clock parked low
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        io0_o = 1'b0;
    end

    // Frame of n pulses, bits MSB first, clock runs only inside
    task automatic send(input logic [23:0] bits, input int n);
        int i;
        cs_n_o = 1'b0;
        for (i = 0; i < n; i++) begin
            io0_o = bits[23 - (i % 24)];
            #6;
            sck_o = 1'b1;
            #6;
            sck_o = 1'b0;
        end
        #6;
        cs_n_o = 1'b1;
        io0_o = ~io0_o; // Released line shows no stale bit
    endtask
endmodule

// >>> flash_command_guard_bench.sv
`timescale 1ns/1ps
// ========================================
// Self-checking bench for the command guard
module flash_command_guard_bench;
    import fcg_pkg::*;
    localparam int PU = 40;
    logic clk, rst, rpin, vmin, vcut, sck, cs_n, io0;
    logic ready, por, acc, dis, write_enable_latch, quad, hwi;
    logic [7:0] opc;
    logic [1:0] lat;
    logic [3:0] dum, mode;
    int failures = 0;
    int cmp_count = 0;
    int acc_n = 0;
    int dis_n = 0;

    fcg_top #(.PU_CYCLES(PU)) dut_u (
        .core_clk_i(clk), .reset_i(rst), .clk_en_i(1'b1), .sck_i(sck), .cs_n_i(cs_n),
        .io0_i(io0), .rst_pin_n_i(rpin), .vcc_min_ok_i(vmin), .vcc_cutoff_ok_i(vcut),
        .ready_o(ready), .por_active_o(por), .cmd_accept_o(acc), .cmd_discard_o(dis),
        .cmd_opcode_o(opc), .write_enable_latch_o(write_enable_latch), .quad_mode_o(quad),
        .hold_wp_ignore_o(hwi), .latency_code_o(lat), .dummy_cycles_o(dum),
        .mode_cycles_o(mode)
    );
    fcg_host_model host_u (.sck_o(sck), .cs_n_o(cs_n), .io0_o(io0));

    // Core clock, 25 ns
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Count answer pulses
    always @(posedge clk) begin
        if (acc === 1'b1) acc_n++;
        if (dis === 1'b1) dis_n++;
    end

    // ========================================
    // Shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (failures == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Bounded wait on por (sel=1) or ready (sel=0)
    task automatic wait_for(input logic sel, input logic want);
        int i;
        for (i = 0; i < 300; i++) begin
            @(posedge clk);
            if ((sel ? por : ready) === want) begin
                #2;
                return;
            end
        end
        failures++;
        $display("ERROR %0t: wait ran out", $time);
        give_verdict();
    endtask

    // Send a frame and count accept and discard pulses
    task automatic cmd(input logic [23:0] bits, input int n, input int ea, input int ed);
        int a0;
        int d0;
        a0 = acc_n;
        d0 = dis_n;
        host_u.send(bits, n);
        repeat (8) @(posedge clk);
        #2;
        check(8'(acc_n - a0), 8'(ea));
        check(8'(dis_n - d0), 8'(ed));
    endtask

    // ========================================
    // Scenarios
    task automatic t_power_up();
        vmin = 1'b1;
        vcut = 1'b1;
        wait_for(1'b1, 1'b1);
        cmd({OP_WRITE_EN, 16'h0000}, 8, 0, 0);
        repeat (PU - 20) @(posedge clk);
        #2;
        check(8'(ready), 8'h00);
        wait_for(1'b0, 1'b1);
        check(8'(write_enable_latch), 8'h00);
        check(8'(por), 8'h00);
    endtask

    task automatic t_pulse_count();
        logic [7:0] ops [4] = '{OP_PAGE_PROG, OP_SECT_ERASE, OP_BULK_ERASE, OP_REG_WRITE};
        int k;
        for (k = 0; k < 4; k++) begin
            cmd({OP_WRITE_EN, 16'h0000}, 8, 1, 0);
            cmd({ops[k], 16'h0000}, 12, 0, 1);
            check(8'(write_enable_latch), 8'h01);
            cmd({ops[k], 16'h0000}, 24, 1, 0);
            check(opc, ops[k]);
            check(8'(write_enable_latch), 8'h00);
        end
    endtask

    task automatic t_config();
        logic [7:0] qops [3] = '{OP_QUAD_OREAD, OP_QUAD_IOREAD, OP_DDR_QIOREAD};
        int k;
        cmd({OP_WRITE_EN, 16'h0000}, 8, 1, 0);
        cmd({OP_REG_WRITE, 16'h00C2}, 24, 1, 0);
        check(8'(lat), 8'h03);
        check({6'h00, quad, hwi}, 8'h03);
        for (k = 0; k < 3; k++) begin
            cmd({qops[k], 16'h0000}, 8, 1, 0);
            check(8'(dum), 8'(DUMMY_TBL[12 +: 4]));
            check(8'(mode), (k > 0) ? 8'(MODE_CYC_QIO) : 8'h00);
        end
        cmd({OP_WRITE_EN, 16'h0000}, 8, 1, 0);
        cmd({OP_REG_WRITE, 16'h0040}, 24, 1, 0);
        check({lat, 5'h00, quad}, 8'h40);
        cmd({OP_FAST_READ, 16'h0000}, 8, 1, 0);
        check(8'(dum), 8'(DUMMY_TBL[4 +: 4]));
        for (k = 0; k < 3; k++) cmd({qops[k], 16'h0000}, 8, 0, 1);
        cmd({OP_WRITE_EN, 16'h0000}, 8, 1, 0);
        cmd({OP_QUAD_PROG, 16'h0000}, 8, 0, 1);
        check({write_enable_latch, 3'h0, mode}, 8'h80);
    endtask

    task automatic t_cutoff();
        vcut = 1'b0;
        wait_for(1'b0, 1'b0);
        cmd({OP_WRITE_EN, 16'h0000}, 8, 0, 0);
        check(8'(write_enable_latch), 8'h00);
        vcut = 1'b1;
        wait_for(1'b0, 1'b1);
        check(8'(lat), 8'h01);
    endtask

    task automatic t_restart();
        vcut = 1'b0;
        vmin = 1'b0;
        wait_for(1'b0, 1'b0);
        vcut = 1'b1;
        vmin = 1'b1;
        wait_for(1'b1, 1'b1);
        vmin = 1'b0;
        wait_for(1'b1, 1'b0);
        vmin = 1'b1;
        repeat (6) @(posedge clk);
        #2;
        check({ready, por}, 8'h00);
        rpin = 1'b0;
        wait_for(1'b1, 1'b1);
        rpin = 1'b1;
        vmin = 1'b0;
        wait_for(1'b1, 1'b0);
        vmin = 1'b1;
        repeat (6) @(posedge clk);
        #2;
        host_u.send({OP_SOFT_RESET, 16'h0000}, 8);
        wait_for(1'b1, 1'b1);
        wait_for(1'b0, 1'b1);
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        rpin = 1'b1;
        vmin = 1'b0;
        vcut = 1'b0;
        repeat (6) @(posedge clk);
        #2;
        rst = 1'b0;
        check(8'(ready), 8'h00);
        t_power_up();
        t_pulse_count();
        t_config();
        t_cutoff();
        t_restart();
        give_verdict();
    end
endmodule
